// *** hw/fcssr_bus_if.sv ***
`timescale 1ns/1ps
interface fcssr_bus_if;
  logic       rd;
  logic       wr;
  logic [1:0] a;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rst_pin;
  logic       int_req;

  modport device (input rd, wr, a, wdata, rst_pin, output rdata, int_req);
  modport host   (output rd, wr, a, wdata, rst_pin, input rdata, int_req);
endinterface

// *** hw/fcssr_defs.svh ***
`ifndef FCSSR_DEFS_SVH
`define FCSSR_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define FCSSR_CLK_NS        25
`define FCSSR_MS_NS         1000000
`define FCSSR_RST_MIN_CYC   4'd10
`define FCSSR_RST_HOLD      4'd10

// ****************************************
// Parallel bus addresses
// ****************************************
`define FCSSR_A_CMD_STAT    2'h0
`define FCSSR_A_PAR_RES     2'h1
`define FCSSR_A_RESET       2'h2

// ****************************************
// Opcodes and specify types
// ****************************************
`define FCSSR_OP_SPECIFY    6'h35
`define FCSSR_OP_SEEK       6'h29
`define FCSSR_OP_DRV_STAT   6'h2c
`define FCSSR_OP_RD_SPEC    6'h3d
`define FCSSR_OP_WR_SPEC    6'h3a
`define FCSSR_SPEC_INIT     8'h0d
`define FCSSR_SPEC_BAD0     8'h10
`define FCSSR_SPEC_BAD1     8'h18

// ****************************************
// Special register addresses
// ****************************************
`define FCSSR_SR_SCAN_SEC   8'h06
`define FCSSR_SR_S0_BT1     8'h10
`define FCSSR_SR_S0_BT2     8'h11
`define FCSSR_SR_S0_CUR     8'h12
`define FCSSR_SR_SCAN_LO    8'h13
`define FCSSR_SR_SCAN_HI    8'h14
`define FCSSR_SR_MODE       8'h17
`define FCSSR_SR_S1_BT1     8'h18
`define FCSSR_SR_S1_BT2     8'h19
`define FCSSR_SR_S1_CUR     8'h1a
`define FCSSR_SR_DRV_IN     8'h22
`define FCSSR_SR_DRV_OUT    8'h23

// ****************************************
// Field positions and values
// ****************************************
`define FCSSR_MODE_RST      8'hc0
`define FCSSR_MODE_SINGLE   1
`define FCSSR_MODE_NODMA    0
`define FCSSR_DI_TRK0       1
`define FCSSR_DI_RDY0       2
`define FCSSR_DI_WPROT      3
`define FCSSR_DI_INDEX      4
`define FCSSR_DI_FAULT      5
`define FCSSR_DI_RDY1       6
`define FCSSR_DO_STEP       1
`define FCSSR_DO_DIR        2
`define FCSSR_DO_HLOAD      3
`define FCSSR_DO_FRST       5
`define FCSSR_DO_SEL0       6
`define FCSSR_DO_SEL1       7
`define FCSSR_RES_GOOD      8'h00
`define FCSSR_RES_TRK0_NF   8'h14
`define FCSSR_MAX_STEPS     8'hff
`define FCSSR_IDX_FOREVER   4'hf

// ****************************************
// Host register offsets
// ****************************************
`define FCSSR_H_CMD         5'h00
`define FCSSR_H_PARAM       5'h04
`define FCSSR_H_SWRST       5'h08
`define FCSSR_H_STATUS      5'h0c
`define FCSSR_H_RESULT      5'h10
`define FCSSR_H_PINRST      5'h14

`endif

// *** hw/fcssr_device.sv ***
`timescale 1ns/1ps
`include "fcssr_defs.svh"
module fcssr_device
  import fcssr_pkg::*;
#(
  parameter int MS_CYCLES = `FCSSR_MS_NS / `FCSSR_CLK_NS
) (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  fcssr_bus_if.device     bus,
  input  wire logic [7:0] drv_in,
  input  wire logic       mini_size,
  output logic [7:0]      drv_out
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [2:0] par_need(input logic [5:0] op);
    case (op)
      `FCSSR_OP_SPECIFY: par_need = 3'd4;
      `FCSSR_OP_SEEK:    par_need = 3'd1;
      `FCSSR_OP_RD_SPEC: par_need = 3'd1;
      `FCSSR_OP_WR_SPEC: par_need = 3'd2;
      default:           par_need = 3'd0;
    endcase
  endfunction

  function automatic logic [9:0] ms_scale(input logic [7:0] v, input logic mini);
    ms_scale = mini ? {1'b0, v, 1'b0} : {2'b00, v};
  endfunction

  // Logical track past each bad track at or below it
  function automatic logic [7:0] phys_track(input logic [7:0] l, input logic [7:0] b1, input logic [7:0] b2);
    logic [7:0] p;
    p = l;
    if (p >= b1) p = p + 8'h01;
    if (p >= b2) p = p + 8'h01;
    phys_track = p;
  endfunction

  // ****************************************
  // State
  // ****************************************
  fcssr_dev_t  r;
  fcssr_dev_t  n;
  logic [8:0]  sync_q;
  logic [7:0]  ri;
  logic        mini;
  logic        tick;
  logic        idx_rise;
  logic        in_reset;
  logic [7:0]  cur;
  logic [7:0]  newcur;
  logic        setcur;
  logic [7:0]  sp_rd;
  logic [7:0]  dstat;

  fcssr_sync #(.W(9)) u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .d       ({mini_size, drv_in}),
    .q       (sync_q)
  );

  assign ri   = sync_q[7:0];
  assign mini = sync_q[8];

  assign drv_out     = r.outp;
  assign bus.rdata   = r.dout;
  assign bus.int_req = r.intr;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n        = r;
    newcur   = 8'h00;
    setcur   = 1'b0;
    tick     = (r.tick_cnt == 16'(MS_CYCLES - 1));
    idx_rise = ri[`FCSSR_DI_INDEX] & ~r.idx_prev;
    cur      = r.sel[1] ? r.s1_cur : r.s0_cur;
    dstat    = ri;
    dstat[`FCSSR_DI_RDY0] = r.rdy_lat[0];
    dstat[`FCSSR_DI_RDY1] = r.rdy_lat[1];
    case (r.prm[0])
      `FCSSR_SR_SCAN_SEC: sp_rd = r.scan_sec;
      `FCSSR_SR_S0_BT1:   sp_rd = r.s0_bt1;
      `FCSSR_SR_S0_BT2:   sp_rd = r.s0_bt2;
      `FCSSR_SR_S0_CUR:   sp_rd = r.s0_cur;
      `FCSSR_SR_SCAN_LO:  sp_rd = r.scan_lo;
      `FCSSR_SR_SCAN_HI:  sp_rd = r.scan_hi;
      `FCSSR_SR_MODE:     sp_rd = r.mode;
      `FCSSR_SR_S1_BT1:   sp_rd = r.s1_bt1;
      `FCSSR_SR_S1_BT2:   sp_rd = r.s1_bt2;
      `FCSSR_SR_S1_CUR:   sp_rd = r.s1_cur;
      `FCSSR_SR_DRV_IN:   sp_rd = ri;
      `FCSSR_SR_DRV_OUT:  sp_rd = r.outp;
      default:            sp_rd = 8'h00;
    endcase

    n.tick_cnt = tick ? 16'h0000 : r.tick_cnt + 16'h0001;
    n.idx_prev = ri[`FCSSR_DI_INDEX];
    n.cmd_full = 1'b0;
    n.par_full = 1'b0;
    n.rdy_lat  = r.rdy_lat & {ri[`FCSSR_DI_RDY1], ri[`FCSSR_DI_RDY0]};
    n.dout     = (bus.a == `FCSSR_A_CMD_STAT) ?
                 {r.busy, r.cmd_full, r.par_full, r.res_full, r.intr, 3'b000} : r.result;
    if (bus.rd && bus.a == `FCSSR_A_PAR_RES) begin
      n.res_full = 1'b0;
      n.intr     = 1'b0;
    end

    if (r.st == DS_IDLE && r.outp[`FCSSR_DO_HLOAD] && idx_rise && r.idx_hl[7:4] != `FCSSR_IDX_FOREVER) begin
      if (r.idx_cnt >= r.idx_hl[7:4]) begin
        n.outp[`FCSSR_DO_HLOAD] = 1'b0;
        n.idx_cnt = 4'h0;
      end else begin
        n.idx_cnt = r.idx_cnt + 4'h1;
      end
    end

    if (bus.wr && bus.a == `FCSSR_A_CMD_STAT && r.st == DS_IDLE) begin
      n.opc      = bus.wdata[5:0];
      n.sel      = bus.wdata[7:6];
      n.pidx     = 3'd0;
      n.busy     = 1'b1;
      n.cmd_full = 1'b1;
      n.idx_cnt  = 4'h0;
      n.st       = DS_PARAM;
    end

    case (r.st)
      DS_IDLE: begin
      end
      DS_PARAM: begin
        if (bus.wr && bus.a == `FCSSR_A_PAR_RES && r.pidx < par_need(r.opc)) begin
          n.prm[r.pidx[1:0]] = bus.wdata;
          n.pidx     = r.pidx + 3'd1;
          n.par_full = 1'b1;
        end else if (r.pidx >= par_need(r.opc)) begin
          n.st = DS_EXEC;
        end
      end
      DS_EXEC: begin
        n.st   = DS_IDLE;
        n.busy = 1'b0;
        case (r.opc)
          `FCSSR_OP_SPECIFY: begin
            case (r.prm[0])
              `FCSSR_SPEC_INIT: begin
                n.step_rate = r.prm[1];
                n.settle    = r.prm[2];
                n.idx_hl    = r.prm[3];
              end
              `FCSSR_SPEC_BAD0: begin
                n.s0_bt1 = r.prm[1];
                n.s0_bt2 = r.prm[2];
                n.s0_cur = r.prm[3];
              end
              `FCSSR_SPEC_BAD1: begin
                n.s1_bt1 = r.prm[1];
                n.s1_bt2 = r.prm[2];
                n.s1_cur = r.prm[3];
              end
              default: begin
              end
            endcase
          end
          `FCSSR_OP_SEEK: begin
            n.busy      = 1'b1;
            n.st        = DS_STEP;
            n.nsteps    = 8'h00;
            n.zero_seek = (r.prm[0] == 8'h00);
            n.tgt       = r.sel[1] ? phys_track(r.prm[0], r.s1_bt1, r.s1_bt2)
                                   : phys_track(r.prm[0], r.s0_bt1, r.s0_bt2);
            n.outp[`FCSSR_DO_SEL0] = r.sel[0];
            n.outp[`FCSSR_DO_SEL1] = r.sel[1];
          end
          `FCSSR_OP_DRV_STAT: begin
            n.result   = dstat;
            n.rdy_lat  = {ri[`FCSSR_DI_RDY1], ri[`FCSSR_DI_RDY0]};
            n.res_full = 1'b1;
            n.intr     = 1'b1;
          end
          `FCSSR_OP_RD_SPEC: begin
            n.result   = sp_rd;
            n.res_full = 1'b1;
            n.intr     = 1'b1;
          end
          `FCSSR_OP_WR_SPEC: begin
            case (r.prm[0])
              `FCSSR_SR_SCAN_SEC: n.scan_sec = r.prm[1];
              `FCSSR_SR_S0_BT1:   n.s0_bt1   = r.prm[1];
              `FCSSR_SR_S0_BT2:   n.s0_bt2   = r.prm[1];
              `FCSSR_SR_S0_CUR:   n.s0_cur   = r.prm[1];
              `FCSSR_SR_SCAN_LO:  n.scan_lo  = r.prm[1];
              `FCSSR_SR_SCAN_HI:  n.scan_hi  = r.prm[1];
              `FCSSR_SR_MODE:     n.mode     = r.prm[1];
              `FCSSR_SR_S1_BT1:   n.s1_bt1   = r.prm[1];
              `FCSSR_SR_S1_BT2:   n.s1_bt2   = r.prm[1];
              `FCSSR_SR_S1_CUR:   n.s1_cur   = r.prm[1];
              `FCSSR_SR_DRV_OUT: begin
                n.outp = r.prm[1];
                if (r.prm[1][`FCSSR_DO_HLOAD] && !r.outp[`FCSSR_DO_HLOAD]) begin
                  n.busy     = 1'b1;
                  n.st       = DS_HLOAD;
                  n.tick_cnt = 16'h0000;
                  n.wait_ms  = mini ? {3'b000, r.idx_hl[3:0], 3'b000} : {4'h0, r.idx_hl[3:0], 2'b00};
                end
              end
              default: begin
              end
            endcase
          end
          default: begin
          end
        endcase
      end
      DS_STEP: begin
        if (r.zero_seek) begin
          if (ri[`FCSSR_DI_TRK0]) begin
            setcur    = 1'b1;
            newcur    = 8'h00;
            n.st      = DS_SETTLE;
            n.wait_ms = ms_scale(r.settle, mini);
          end else if (r.nsteps == `FCSSR_MAX_STEPS) begin
            n.result   = `FCSSR_RES_TRK0_NF;
            n.res_full = 1'b1;
            n.intr     = 1'b1;
            n.busy     = 1'b0;
            n.st       = DS_IDLE;
          end else begin
            n.outp[`FCSSR_DO_DIR]  = 1'b0;
            n.outp[`FCSSR_DO_STEP] = 1'b1;
            n.nsteps  = r.nsteps + 8'h01;
            n.st      = DS_STEPW;
            n.wait_ms = ms_scale(r.step_rate, mini);
          end
        end else if (cur == r.tgt) begin
          n.st      = DS_SETTLE;
          n.wait_ms = ms_scale(r.settle, mini);
        end else begin
          setcur    = 1'b1;
          newcur    = (r.tgt > cur) ? cur + 8'h01 : cur - 8'h01;
          n.outp[`FCSSR_DO_DIR]  = (r.tgt > cur);
          n.outp[`FCSSR_DO_STEP] = 1'b1;
          n.st      = DS_STEPW;
          n.wait_ms = ms_scale(r.step_rate, mini);
        end
        n.tick_cnt = 16'h0000;
      end
      DS_STEPW: begin
        if (tick || r.wait_ms == 10'd0) n.outp[`FCSSR_DO_STEP] = 1'b0;
        if (r.wait_ms == 10'd0) n.st = DS_STEP;
        else if (tick) n.wait_ms = r.wait_ms - 10'd1;
      end
      DS_SETTLE: begin
        if (r.wait_ms == 10'd0) begin
          n.result   = `FCSSR_RES_GOOD;
          n.res_full = 1'b1;
          n.intr     = 1'b1;
          n.busy     = 1'b0;
          n.st       = DS_IDLE;
        end else if (tick) begin
          n.wait_ms = r.wait_ms - 10'd1;
        end
      end
      DS_HLOAD: begin
        if (r.wait_ms == 10'd0) begin
          n.busy = 1'b0;
          n.st   = DS_IDLE;
        end else if (tick) begin
          n.wait_ms = r.wait_ms - 10'd1;
        end
      end
      default: n.st = DS_IDLE;
    endcase

    if (setcur) begin
      if (r.sel[1] || r.mode[`FCSSR_MODE_SINGLE]) n.s1_cur = newcur;
      if (!r.sel[1] || r.mode[`FCSSR_MODE_SINGLE]) n.s0_cur = newcur;
    end

    // pin must stay high ten clocks
    n.rst_cnt = !bus.rst_pin ? 4'h0 : (r.rst_cnt >= `FCSSR_RST_MIN_CYC) ? r.rst_cnt : r.rst_cnt + 4'h1;
    if (bus.wr && bus.a == `FCSSR_A_RESET) n.soft_rst = bus.wdata[0];
    in_reset = (r.rst_cnt >= `FCSSR_RST_MIN_CYC) || r.soft_rst;
    if (in_reset) begin
      n          = '0;
      n.st       = DS_IDLE;
      n.mode     = `FCSSR_MODE_RST;
      n.rst_cnt  = (bus.rst_pin && r.rst_cnt >= `FCSSR_RST_MIN_CYC) ? r.rst_cnt : 4'h0;
      n.soft_rst = (bus.wr && bus.a == `FCSSR_A_RESET) ? bus.wdata[0] : r.soft_rst;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r      <= '0;
      r.st   <= DS_IDLE;
      r.mode <= `FCSSR_MODE_RST;
    end else begin
      r <= n;
    end
  end

endmodule

// *** hw/fcssr_host.sv ***
`timescale 1ns/1ps
`include "fcssr_defs.svh"
module fcssr_host
  import fcssr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  fcssr_bus_if.host        bus,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  fcssr_host_t r;
  fcssr_host_t n;

  assign bus.rd          = r.rd;
  assign bus.wr          = r.wr;
  assign bus.a           = r.a;
  assign bus.wdata       = r.wdata;
  assign bus.rst_pin     = r.rst_pin;
  assign avs_readdata    = r.rdata;
  assign avs_waitrequest = r.wreq;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n    = r;
    n.rd = 1'b0;
    n.wr = 1'b0;
    case (r.st)
      HS_IDLE: begin
        n.wreq = 1'b1;
        if (avs_write) begin
          n.wdata = avs_writedata[7:0];
          n.st    = HS_STROBE;
          case (avs_address)
            `FCSSR_H_CMD: begin
              n.wr = 1'b1;
              n.a  = `FCSSR_A_CMD_STAT;
            end
            `FCSSR_H_PARAM: begin
              n.wr = 1'b1;
              n.a  = `FCSSR_A_PAR_RES;
            end
            `FCSSR_H_SWRST: begin
              n.wr = 1'b1;
              n.a  = `FCSSR_A_RESET;
            end
            `FCSSR_H_PINRST: begin
              n.rst_pin = 1'b1;
              n.cnt     = 4'h0;
              n.st      = HS_RHOLD;
            end
            default: begin
              n.wreq = 1'b0;
              n.st   = HS_ANSWER;
            end
          endcase
        end else if (avs_read) begin
          n.st = HS_STROBE;
          case (avs_address)
            `FCSSR_H_STATUS: begin
              n.rd = 1'b1;
              n.a  = `FCSSR_A_CMD_STAT;
            end
            `FCSSR_H_RESULT: begin
              n.rd = 1'b1;
              n.a  = `FCSSR_A_PAR_RES;
            end
            default: begin
              n.rdata = 32'h0000_0000;
              n.wreq  = 1'b0;
              n.st    = HS_ANSWER;
            end
          endcase
        end
      end
      HS_STROBE: n.st = HS_WAIT;
      HS_WAIT: begin
        n.rdata = {24'h000000, bus.rdata};
        n.wreq  = 1'b0;
        n.st    = HS_ANSWER;
      end
      HS_ANSWER: begin
        n.wreq = 1'b1;
        n.st   = HS_IDLE;
      end
      HS_RHOLD: begin
        if (r.cnt >= `FCSSR_RST_HOLD) begin
          n.rst_pin = 1'b0;
          n.wreq    = 1'b0;
          n.st      = HS_ANSWER;
        end else begin
          n.cnt = r.cnt + 4'h1;
        end
      end
      default: n.st = HS_IDLE;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      r      <= '0;
      r.st   <= HS_IDLE;
      r.wreq <= 1'b1;
    end else begin
      r <= n;
    end
  end

endmodule

// *** hw/fcssr_pkg.sv ***
package fcssr_pkg;

  typedef enum logic [6:0] {
    DS_IDLE   = 7'b0000001,
    DS_PARAM  = 7'b0000010,
    DS_EXEC   = 7'b0000100,
    DS_STEP   = 7'b0001000,
    DS_STEPW  = 7'b0010000,
    DS_SETTLE = 7'b0100000,
    DS_HLOAD  = 7'b1000000
  } fcssr_dstate_t;

  typedef enum logic [4:0] {
    HS_IDLE   = 5'b00001,
    HS_STROBE = 5'b00010,
    HS_WAIT   = 5'b00100,
    HS_ANSWER = 5'b01000,
    HS_RHOLD  = 5'b10000
  } fcssr_hstate_t;

  typedef struct packed {
    fcssr_dstate_t   st;
    logic [5:0]      opc;
    logic [1:0]      sel;
    logic [2:0]      pidx;
    logic [3:0][7:0] prm;
    logic            busy;
    logic            cmd_full;
    logic            par_full;
    logic            res_full;
    logic            intr;
    logic [7:0]      result;
    logic [7:0]      dout;
    logic [7:0]      step_rate;
    logic [7:0]      settle;
    logic [7:0]      idx_hl;
    logic [7:0]      mode;
    logic [7:0]      scan_sec;
    logic [7:0]      scan_lo;
    logic [7:0]      scan_hi;
    logic [7:0]      s0_bt1;
    logic [7:0]      s0_bt2;
    logic [7:0]      s0_cur;
    logic [7:0]      s1_bt1;
    logic [7:0]      s1_bt2;
    logic [7:0]      s1_cur;
    logic [7:0]      outp;
    logic [1:0]      rdy_lat;
    logic            zero_seek;
    logic [7:0]      tgt;
    logic [7:0]      nsteps;
    logic [9:0]      wait_ms;
    logic [15:0]     tick_cnt;
    logic [3:0]      idx_cnt;
    logic            idx_prev;
    logic [3:0]      rst_cnt;
    logic            soft_rst;
  } fcssr_dev_t;

  typedef struct packed {
    fcssr_hstate_t st;
    logic          rd;
    logic          wr;
    logic [1:0]    a;
    logic [7:0]    wdata;
    logic          rst_pin;
    logic [31:0]   rdata;
    logic          wreq;
    logic [3:0]    cnt;
  } fcssr_host_t;

endpackage

// *** hw/fcssr_sync.sv ***
`timescale 1ns/1ps
module fcssr_sync #(
  parameter int W = 9
) (
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// *** tb/fcssr_chk.sv ***
`timescale 1ns/1ps
// ********
// Bus and drive pin checks
// ********
module fcssr_chk (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       rd,
  input wire logic       wr,
  input wire logic [1:0] a,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rst_pin,
  input wire logic       int_req,
  input wire logic [7:0] drv_in,
  input wire logic [7:0] drv_out
);
  logic [3:0] rst_hi_cnt_r;

  // Consecutive cycles of pin reset high
  always_ff @(posedge ref_clk) begin
    if (srst || !rst_pin) begin
      rst_hi_cnt_r <= 4'h0;
    end else if (rst_hi_cnt_r != 4'hf) begin
      rst_hi_cnt_r <= rst_hi_cnt_r + 4'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_strobe_pulse: assert property ((rd || wr) |-> !(rd && wr) ##1 !(rd || wr))
    else $error("strobe not a single pulse");
  a_pin_reset: assert property ((rst_pin && rst_hi_cnt_r >= 4'd9) |-> ##[1:2] (drv_out == 8'h00 && !int_req))
    else $error("pin reset left outputs set");
  a_soft_reset: assert property ((wr && a == 2'h2 && wdata[0]) |-> ##[2:3] (drv_out == 8'h00 && !int_req))
    else $error("soft reset left outputs set");
  a_int_clear: assert property ((rd && a == 2'h1) |=> !int_req)
    else $error("result read kept interrupt");
  a_status_int: assert property ((a == 2'h0 && !rst_pin) |=> rdata[3] == $past(int_req))
    else $error("status interrupt bit differs");
  a_status_spare: assert property (a == 2'h0 |=> rdata[2:0] == 3'h0)
    else $error("status low bits set");
  a_step_width: assert property ($rose(drv_out[1]) |-> ##[1:5] !drv_out[1])
    else $error("step pulse too long");
  a_seek_no_load: assert property ($rose(drv_out[1]) |-> !drv_out[3])
    else $error("head loaded while stepping");
  a_trk0_stop: assert property (drv_in[1] [*6] |-> !($rose(drv_out[1]) && !drv_out[2]))
    else $error("outward step at track zero");
  c_step: cover property ($rose(drv_out[1]));
  c_int: cover property ($rose(int_req));
  c_pin_reset: cover property (rst_pin && rst_hi_cnt_r >= 4'd9);
endmodule

// *** tb/floppy_ctrl_setup_seek_regs_tb.sv ***
`timescale 1ns/1ps
`include "fcssr_defs.svh"
module floppy_ctrl_setup_seek_regs_tb;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  drv_in = 8'h44;
  logic        mini_size = 1'b0;
  logic [7:0]  drv_out;
  logic [7:0]  r;
  logic [7:0]  steps = 8'h00;
  logic        step_q = 1'b0;
  int          cyc = 0;
  int          last = 0;
  int          gap = 0;
  int          error_cnt = 0;
  int          checks = 0;
  logic [7:0]  sr_a [9] = '{8'h10, 8'h11, 8'h12, 8'h18, 8'h19, 8'h1a, 8'h06, 8'h13, 8'h14};
  logic [7:0]  sr_v [9] = '{8'h03, 8'h05, 8'h00, 8'hff, 8'hff, 8'hff, 8'h5a, 8'ha5, 8'h3c};

  always #12.5 ref_clk = ~ref_clk;

  fcssr_bus_if bus_if ();
  fcssr_host fcssr_host_inst (.ref_clk(ref_clk), .srst(srst), .bus(bus_if),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  fcssr_device #(.MS_CYCLES(4)) fcssr_device_inst (.ref_clk(ref_clk), .srst(srst), .bus(bus_if),
    .drv_in(drv_in), .mini_size(mini_size), .drv_out(drv_out));
  fcssr_chk fcssr_chk_inst (.ref_clk(ref_clk), .srst(srst), .rd(bus_if.rd), .wr(bus_if.wr),
    .a(bus_if.a), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .rst_pin(bus_if.rst_pin),
    .int_req(bus_if.int_req), .drv_in(drv_in), .drv_out(drv_out));

  // ********
  // Step pulse counter
  // ********
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    step_q <= drv_out[1];
    if (drv_out[1] && !step_q) begin
      steps <= steps + 8'h01;
      gap <= cyc - last;
      last <= cyc;
    end
  end

  // ********
  // Bus tasks
  // ********
  task av_wr(input logic [4:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    avs_address <= ad;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task av_rd(input logic [4:0] ad, output logic [7:0] d);
    @(posedge ref_clk);
    avs_address <= ad;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata[7:0];
    avs_read <= 1'b0;
  endtask

  task cmd(input logic [5:0] op);
    av_wr(`FCSSR_H_CMD, {2'b00, op});
  endtask

  task par(input logic [7:0] d);
    av_wr(`FCSSR_H_PARAM, d);
  endtask

  task idle;
    logic [7:0] s;
    s = 8'h80;
    while (s[7] !== 1'b0) av_rd(`FCSSR_H_STATUS, s);
  endtask

  task fin(output logic [7:0] res);
    idle();
    av_rd(`FCSSR_H_RESULT, res);
  endtask

  task spec(input logic [7:0] t, input logic [7:0] p1, input logic [7:0] p2, input logic [7:0] p3);
    cmd(`FCSSR_OP_SPECIFY);
    par(t);
    par(p1);
    par(p2);
    par(p3);
    idle();
  endtask

  task rd_spec(input logic [7:0] ad, output logic [7:0] res);
    cmd(`FCSSR_OP_RD_SPEC);
    par(ad);
    fin(res);
  endtask

  task wr_spec(input logic [7:0] ad, input logic [7:0] d);
    cmd(`FCSSR_OP_WR_SPEC);
    par(ad);
    par(d);
    idle();
  endtask

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task results;
    $display("Checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ********
  // Tests
  // ********
  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    av_rd(`FCSSR_H_STATUS, r);
    chk8(r, 8'h00);
    rd_spec(`FCSSR_SR_MODE, r);
    chk8(r, `FCSSR_MODE_RST);
    $display("Test reset done");
    spec(`FCSSR_SPEC_INIT, 8'h02, 8'h01, 8'hf1);
    av_rd(`FCSSR_H_STATUS, r);
    chk8(r, 8'h00);
    spec(`FCSSR_SPEC_BAD0, 8'h03, 8'h05, 8'h00);
    spec(`FCSSR_SPEC_BAD1, 8'hff, 8'hff, 8'hff);
    for (int i = 6; i < 9; i++) wr_spec(sr_a[i], sr_v[i]);
    for (int i = 0; i < 9; i++) begin
      rd_spec(sr_a[i], r);
      chk8(r, sr_v[i]);
    end
    $display("Test specify done");
    steps <= 8'h00;
    cmd(`FCSSR_OP_SEEK);
    par(8'h04);
    fin(r);
    chk8(r, `FCSSR_RES_GOOD);
    chk8(steps, 8'h06);
    chk8({7'h0, gap >= 8 && gap <= 16}, 8'h01);
    rd_spec(`FCSSR_SR_DRV_OUT, r);
    chk8(r & 8'h08, 8'h00);
    steps <= 8'h00;
    cmd(`FCSSR_OP_SEEK);
    par(8'h00);
    fin(r);
    chk8(r, `FCSSR_RES_TRK0_NF);
    chk8(steps, `FCSSR_MAX_STEPS);
    drv_in <= 8'h46;
    steps <= 8'h00;
    cmd(`FCSSR_OP_SEEK);
    par(8'h00);
    fin(r);
    chk8(r, `FCSSR_RES_GOOD);
    chk8(steps, 8'h00);
    drv_in <= 8'h44;
    mini_size <= 1'b1;
    steps <= 8'h00;
    cmd(`FCSSR_OP_SEEK);
    par(8'h02);
    fin(r);
    chk8(steps, 8'h02);
    chk8({7'h0, gap >= 16 && gap <= 24}, 8'h01);
    mini_size <= 1'b0;
    $display("Test seek done");
    cmd(`FCSSR_OP_DRV_STAT);
    fin(r);
    chk8(r, 8'h00);
    cmd(`FCSSR_OP_DRV_STAT);
    fin(r);
    chk8(r, 8'h44);
    drv_in <= 8'h40;
    repeat (4) @(posedge ref_clk);
    drv_in <= 8'h44;
    rd_spec(`FCSSR_SR_DRV_IN, r);
    chk8(r, 8'h44);
    cmd(`FCSSR_OP_DRV_STAT);
    fin(r);
    chk8(r, 8'h40);
    $display("Test drive status done");
    wr_spec(`FCSSR_SR_DRV_OUT, 8'h21);
    chk8(drv_out, 8'h21);
    wr_spec(`FCSSR_SR_MODE, 8'hc3);
    rd_spec(`FCSSR_SR_MODE, r);
    chk8(r, 8'hc3);
    cmd(`FCSSR_OP_SEEK);
    par(8'h01);
    fin(r);
    rd_spec(`FCSSR_SR_S1_CUR, r);
    chk8(r, 8'h01);
    av_wr(`FCSSR_H_SWRST, 8'h01);
    av_wr(`FCSSR_H_SWRST, 8'h00);
    chk8(drv_out, 8'h00);
    rd_spec(`FCSSR_SR_MODE, r);
    chk8(r, `FCSSR_MODE_RST);
    wr_spec(`FCSSR_SR_DRV_OUT, 8'h20);
    av_wr(`FCSSR_H_PINRST, 8'h00);
    chk8(drv_out, 8'h00);
    $display("Test resets done");
    results();
  end

  initial begin
    #(25 * 40000);
    error_cnt++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    results();
  end
endmodule
